// File: pkg/tcs_cfg.svh
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH
// Function
// - select code 0x1 ticks the counter on every system clock
// - select codes 2 to 5 pick prescaler taps of 8, 64, 256, 1024
// - prescaler runs freely, so first prescaled tick comes 1 to N+1 clocks later
// - prescaler reset restarts the division for every timer sharing it
// - external input sampled each clock through latch and flop before edge detection
// - one tick per rising edge at code 0x7, per falling edge at 0x6
// - external edge reaches counter 2.5 to 3.5 clocks after it arrives; this model, with the latch as a flop, takes 2 to 3 clocks
// - external ticks never pass through the prescaler
// - 16-bit up/down counter with count, direction, clear, ceiling and floor
// - high location is the holding byte; low read loads it, low write uses it
// - select code 0x0 stops counting but count stays readable and writable
// - processor write beats clear or count in the same cycle
// - counter clears, counts up or down per waveform mode on each tick
// - overflow flag set at the mode-defined point and drives an interrupt
// - one holding byte is shared by every 16-bit timer register

// register addresses
`define TCS_ADDR_CTRL_A 3'h0
`define TCS_ADDR_CTRL_B 3'h1
`define TCS_ADDR_CNT_LO 3'h2
`define TCS_ADDR_CNT_HI 3'h3
`define TCS_ADDR_FLAGS 3'h4
`define TCS_ADDR_PRESC 3'h5
`define TCS_ADDR_CEIL_LO 3'h6
`define TCS_ADDR_CEIL_HI 3'h7
// field positions
`define TCS_CS_LSB 0
`define TCS_WGM_HI_LSB 3
`define TCS_WGM_LO_LSB 0
`define TCS_OVF_BIT 0
`define TCS_PRST_BIT 0
// reset values
`define TCS_RST_CS 3'h0
`define TCS_RST_WGM 4'h0
`define TCS_RST_CEIL 16'hffff
// prescaler taps, as the last counter value of each period
`define TCS_DIV8_LAST 10'h007
`define TCS_DIV64_LAST 10'h03f
`define TCS_DIV256_LAST 10'h0ff
`define TCS_DIV1024_LAST 10'h3ff
`endif

// File: pkg/tcs_pkg.sv
package tcs_pkg;
	typedef enum logic [2:0] {
		TCS_SRC_OFF = 3'h0,
		TCS_SRC_CLK = 3'h1,
		TCS_SRC_D8 = 3'h2,
		TCS_SRC_D64 = 3'h3,
		TCS_SRC_D256 = 3'h4,
		TCS_SRC_D1024 = 3'h5,
		TCS_SRC_FALL = 3'h6,
		TCS_SRC_RISE = 3'h7
	} tcs_src_t;
	typedef enum logic [1:0] {
		TCS_DIR_UP,
		TCS_DIR_DOWN
	} tcs_dir_t;
endpackage

// File: rtl/tcs_prescaler.sv
`timescale 1ns/100ps
`include "tcs_cfg.svh"
module tcs_prescaler import tcs_pkg::*; #(
	parameter int WIDTH = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// shared restart
	input wire logic presc_clear,
	// taps, one-cycle pulses
	output logic tap8,
	output logic tap64,
	output logic tap256,
	output logic tap1024
);
	logic [WIDTH-1:0] div_reg;

	// free running, select has no influence
	always_ff @(posedge clk) begin
		if (!rst_b || presc_clear) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end

	always_comb begin
		tap8 = (div_reg[2:0] == 3'(`TCS_DIV8_LAST));
		tap64 = (div_reg[5:0] == 6'(`TCS_DIV64_LAST));
		tap256 = (div_reg[7:0] == 8'(`TCS_DIV256_LAST));
		tap1024 = (div_reg == WIDTH'(`TCS_DIV1024_LAST));
	end
endmodule

// File: rtl/tcs_ext_sync.sv
`timescale 1ns/100ps
`include "tcs_cfg.svh"
module tcs_ext_sync import tcs_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// pin
	input wire logic ext_count_input,
	// edge pulses
	output logic rise_pulse,
	output logic fall_pulse
);
	logic samp_reg;
	logic sync_reg;
	logic prev_reg;

	// the latch half stage is modelled as a plain flop; the extra half cycle of
	// the original latch is lost, so total delay sits at the lower end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			samp_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			samp_reg <= ext_count_input;
			sync_reg <= samp_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= sync_reg;
		end
	end

	// edge detect stays combinational: a registered stage would push pin-to-count to four clocks
	always_comb begin
		rise_pulse = sync_reg && !prev_reg;
		fall_pulse = !sync_reg && prev_reg;
	end
endmodule

// File: rtl/tcs_timer.sv
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "tcs_cfg.svh"
module tcs_timer import tcs_pkg::*; #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// external count pin
	input wire logic ext_count_input,
	// status toward compare and interrupt logic
	output logic [CNT_W-1:0] count_value,
	output logic timer_tick,
	output logic count_ceiling,
	output logic count_floor,
	output logic overflow_flag,
	output logic overflow_irq
);
	logic [7:0] timer_control_a;
	logic [7:0] timer_control_b;
	logic [7:0] hold_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic [CNT_W-1:0] ceil_reg;
	logic ovf_reg;
	logic ovf_set;
	tcs_dir_t dir_reg;
	logic [3:0] waveform_mode_field;
	tcs_src_t tick_source_select;
	logic presc_clear;
	logic tap8, tap64, tap256, tap1024;
	logic rise_pulse, fall_pulse;
	logic wr_cnt;

	function automatic logic hit(input logic [2:0] a);
		return reg_wr && (reg_addr == a);
	endfunction

	assign tick_source_select = tcs_src_t'(timer_control_b[`TCS_CS_LSB +: 3]);
	assign waveform_mode_field = {timer_control_b[`TCS_WGM_HI_LSB +: 2],
		timer_control_a[`TCS_WGM_LO_LSB +: 2]};
	assign presc_clear = hit(`TCS_ADDR_PRESC) && reg_wdata[`TCS_PRST_BIT];
	assign wr_cnt = hit(`TCS_ADDR_CNT_LO);

	tcs_prescaler #(.WIDTH(10)) u_presc (
		.clk(clk),
		.rst_b(rst_b),
		.presc_clear(presc_clear),
		.tap8(tap8),
		.tap64(tap64),
		.tap256(tap256),
		.tap1024(tap1024)
	);

	tcs_ext_sync u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.ext_count_input(ext_count_input),
		.rise_pulse(rise_pulse),
		.fall_pulse(fall_pulse)
	);

	// tick source mux; external edges bypass the prescaler
	always_comb begin
		case (tick_source_select)
			TCS_SRC_OFF: timer_tick = 1'b0;
			TCS_SRC_CLK: timer_tick = 1'b1;
			TCS_SRC_D8: timer_tick = tap8;
			TCS_SRC_D64: timer_tick = tap64;
			TCS_SRC_D256: timer_tick = tap256;
			TCS_SRC_D1024: timer_tick = tap1024;
			TCS_SRC_FALL: timer_tick = fall_pulse;
			TCS_SRC_RISE: timer_tick = rise_pulse;
			default: timer_tick = 1'b0;
		endcase
	end

	// control registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			timer_control_a <= 8'h00;
			timer_control_b <= 8'h00;
			ceil_reg <= `TCS_RST_CEIL;
		end else begin
			if (hit(`TCS_ADDR_CTRL_A)) begin
				timer_control_a <= reg_wdata;
			end
			if (hit(`TCS_ADDR_CTRL_B)) begin
				timer_control_b <= reg_wdata;
			end
			if (hit(`TCS_ADDR_CEIL_LO)) begin
				ceil_reg <= {hold_reg, reg_wdata};
			end
		end
	end

	// one holding byte shared by counter and ceiling
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hold_reg <= 8'h00;
		end else if (hit(`TCS_ADDR_CNT_HI) || hit(`TCS_ADDR_CEIL_HI)) begin
			hold_reg <= reg_wdata;
		end else if (reg_rd && reg_addr == `TCS_ADDR_CNT_LO) begin
			hold_reg <= cnt_reg[15:8];
		end else if (reg_rd && reg_addr == `TCS_ADDR_CEIL_LO) begin
			hold_reg <= ceil_reg[15:8];
		end
	end

	// ceiling and floor, as seen by the compare and waveform logic
	assign count_ceiling = (cnt_reg == ceil_reg);
	assign count_floor = (cnt_reg == '0);

	// modes: 0 up then wrap, 4 and 12 up then clear at ceiling, else up/down at ceiling
	always_comb begin
		cnt_next = cnt_reg;
		ovf_set = 1'b0;
		if (timer_tick) begin
			case (waveform_mode_field)
				4'h0: begin
					cnt_next = cnt_reg + 1'b1;
					ovf_set = &cnt_reg;
				end
				4'h4, 4'hc: begin
					cnt_next = count_ceiling ? '0 : cnt_reg + 1'b1;
					ovf_set = &cnt_reg;
				end
				default: begin
					if (dir_reg == TCS_DIR_UP) begin
						cnt_next = count_ceiling ? cnt_reg - 1'b1 : cnt_reg + 1'b1;
					end else begin
						cnt_next = count_floor ? cnt_reg + 1'b1 : cnt_reg - 1'b1;
						ovf_set = count_floor;
					end
				end
			endcase
		end
	end

	// processor write wins over any count this cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_reg <= '0;
		end else if (wr_cnt) begin
			cnt_reg <= {hold_reg, reg_wdata};
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dir_reg <= TCS_DIR_UP;
		end else if (timer_tick && !wr_cnt) begin
			if (count_ceiling) begin
				dir_reg <= TCS_DIR_DOWN;
			end else if (count_floor) begin
				dir_reg <= TCS_DIR_UP;
			end
		end
	end

	// set beats a same-cycle write-one clear
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ovf_reg <= 1'b0;
		end else if (ovf_set && !wr_cnt) begin
			ovf_reg <= 1'b1;
		end else if (hit(`TCS_ADDR_FLAGS) && reg_wdata[`TCS_OVF_BIT]) begin
			ovf_reg <= 1'b0;
		end
	end

	// high location read returns the holding byte
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`TCS_ADDR_CTRL_A: reg_rdata <= timer_control_a;
				`TCS_ADDR_CTRL_B: reg_rdata <= timer_control_b;
				`TCS_ADDR_CNT_LO: reg_rdata <= cnt_reg[7:0];
				`TCS_ADDR_CNT_HI: reg_rdata <= hold_reg;
				`TCS_ADDR_FLAGS: reg_rdata <= {7'h00, ovf_reg};
				`TCS_ADDR_CEIL_LO: reg_rdata <= ceil_reg[7:0];
				`TCS_ADDR_CEIL_HI: reg_rdata <= hold_reg;
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	assign count_value = cnt_reg;
	assign overflow_flag = ovf_reg;
	assign overflow_irq = ovf_reg;
endmodule

// File: testbench/tcs_timer_assertions.sv
`timescale 1ns/100ps
module tcs_timer_chk import tcs_pkg::*; #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// pin and status
	input wire logic ext_count_input,
	input wire logic [CNT_W-1:0] count_value,
	input wire logic timer_tick,
	input wire logic count_ceiling,
	input wire logic count_floor,
	input wire logic overflow_flag,
	input wire logic overflow_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic lo_wr;
	assign lo_wr = reg_wr && reg_addr == 3'h2;
	property p_floor; count_floor == (count_value == '0); endproperty
	property p_irq; overflow_irq == overflow_flag; endproperty
	property p_lo_write; lo_wr |=> count_value[7:0] == $past(reg_wdata); endproperty
	property p_hi_write;
		reg_wr && reg_addr == 3'h3 ##1 lo_wr |=> count_value[15:8] == $past(reg_wdata, 2);
	endproperty
	property p_lo_read; reg_rd && reg_addr == 3'h2 |=> reg_rdata == 8'($past(count_value));
	endproperty
	sequence s_rd16; reg_rd && reg_addr == 3'h2 ##1 reg_rd && reg_addr == 3'h3; endsequence
	property p_hi_read; s_rd16 |=> reg_rdata == 8'($past(count_value, 2) >> 8); endproperty
	// no tick and no low write means the count must hold
	property p_stop; !timer_tick && !lo_wr |=> $stable(count_value); endproperty
	property p_ovf_cause; $rose(overflow_flag) |-> $past(timer_tick) && !$past(lo_wr); endproperty
	property p_reset;
		$rose(rst_b) |-> count_value == '0 && reg_rdata == 8'h00 && !overflow_flag;
	endproperty
	a_floor: assert property (p_floor) else $error("floor flag wrong");
	a_irq: assert property (p_irq) else $error("irq differs from flag");
	a_lo_write: assert property (p_lo_write) else $error("low write lost");
	a_hi_write: assert property (p_hi_write) else $error("holding byte not used");
	a_lo_read: assert property (p_lo_read) else $error("low read wrong");
	a_hi_read: assert property (p_hi_read) else $error("high read wrong");
	a_stop: assert property (p_stop) else $error("count moved without tick");
	a_ovf_cause: assert property (p_ovf_cause) else $error("flag set without tick");
	a_reset: assert property (p_reset) else $error("reset value wrong");
	c_ovf: cover property ($rose(overflow_flag));
	c_rd16: cover property (s_rd16);
	c_wrap: cover property (timer_tick && count_floor);
endmodule
bind tcs_timer tcs_timer_chk #(.CNT_W(CNT_W)) i_chk (.clk, .rst_b, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .ext_count_input, .count_value, .timer_tick,
	.count_ceiling, .count_floor, .overflow_flag, .overflow_irq);

// File: testbench/tcs_cpu_model.sv
`timescale 1ns/100ps
module tcs_cpu_model import tcs_pkg::*; (
	// clock
	input wire logic clk,
	// register port
	output logic [2:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// external count pin
	output logic ext_count_input
);
	initial begin
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ext_count_input = 1'b0;
	end
	// stale data is inverted so a late sample cannot pass by luck
	task wr8(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	// both strobes back to back, nothing can slip in between
	task wr16(input logic [2:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a + 3'h1;
		reg_wdata <= v[15:8];
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v[7:0];
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~v[7:0];
	endtask
	task rd16(input logic [2:0] a, output logic [15:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_addr <= a + 3'h1;
		@(negedge clk);
		v[7:0] = reg_rdata;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		v[15:8] = reg_rdata;
	endtask
	// half periods of h cycles, h above one keeps sampling safe
	// single pin change right after an edge, for latency measurement
	task ext_edge(input logic lvl);
		@(posedge clk);
		ext_count_input <= lvl;
	endtask
	task ext_pulses(input int n, input int h);
		repeat (n) begin
			repeat (h) @(posedge clk);
			ext_count_input <= 1'b1;
			repeat (h) @(posedge clk);
			ext_count_input <= 1'b0;
		end
		repeat (h) @(posedge clk);
	endtask
endmodule

// File: testbench/timer_clock_select_and_counter_tb_top.sv
`timescale 1ns/100ps
module timer_clock_select_and_counter_tb_top import tcs_pkg::*;;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, ext_count_input;
	logic [15:0] count_value;
	logic timer_tick, count_ceiling, count_floor, overflow_flag, overflow_irq;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	always #4 clk = ~clk;
	tcs_cpu_model i_cpu (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_input(ext_count_input));
	tcs_timer i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_count_input(ext_count_input), .count_value(count_value), .timer_tick(timer_tick),
		.count_ceiling(count_ceiling), .count_floor(count_floor),
		.overflow_flag(overflow_flag), .overflow_irq(overflow_irq));
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task wait_tick(output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (timer_tick !== 1'b1 && n < 2000);
	endtask
	task t_access;
		logic [15:0] v;
		check("reset count", count_value, 16'h0000);
		i_cpu.wr16(3'h2, 16'h01ff);
		@(negedge clk);
		check("write16", count_value, 16'h01ff);
		repeat (10) @(negedge clk);
		check("stopped", count_value, 16'h01ff);
		i_cpu.rd16(3'h2, v);
		check("read16", v, 16'h01ff);
		i_cpu.wr8(3'h2, 8'h34);
		@(negedge clk);
		check("reused high", count_value, 16'h0134);
		i_cpu.wr16(3'h6, 16'habcd);
		i_cpu.wr8(3'h2, 8'h00);
		@(negedge clk);
		check("shared high", count_value, 16'hab00);
		i_cpu.wr16(3'h6, 16'hffff);
		$display("access test done");
	endtask
	task t_clk;
		logic [15:0] c;
		i_cpu.wr16(3'h2, 16'h0000);
		i_cpu.wr8(3'h1, 8'h01);
		@(negedge clk);
		c = count_value;
		repeat (5) @(negedge clk);
		check("free run", count_value, c + 16'h0005);
		i_cpu.wr16(3'h2, 16'hfffe);
		@(negedge clk);
		check("override", count_value, 16'hfffe);
		repeat (2) @(negedge clk);
		check("wrap", count_value, 16'h0000);
		check("overflow", overflow_flag, 1'b1);
		i_cpu.wr8(3'h1, 8'h00);
		i_cpu.wr8(3'h4, 8'h01);
		@(negedge clk);
		check("overflow clear", overflow_flag, 1'b0);
		$display("clock test done");
	endtask
	task t_presc;
		int dv[4] = '{8, 64, 256, 1024};
		int n;
		for (int i = 0; i < 4; i++) begin
			i_cpu.wr8(3'h5, 8'h01);
			i_cpu.wr8(3'h1, 8'(i + 2));
			wait_tick(n);
			check("first tick", 16'(n <= dv[i] + 1), 16'h0001);
			wait_tick(n);
			check("tap period", 16'(n), 16'(dv[i]));
			i_cpu.wr8(3'h1, 8'h00);
		end
		$display("prescaler test done");
	endtask
	task t_ext;
		i_cpu.wr16(3'h2, 16'h0000);
		// pin is low and steady while the source changes
		i_cpu.wr8(3'h1, 8'h07);
		// pin changes just after an edge: count must move three clocks later
		i_cpu.ext_edge(1'b1);
		repeat (3) @(negedge clk);
		check("edge early", count_value, 16'h0000);
		@(negedge clk);
		check("edge latency", count_value, 16'h0001);
		i_cpu.ext_edge(1'b0);
		i_cpu.ext_pulses(5, 3);
		repeat (6) @(negedge clk);
		check("rise ticks", count_value, 16'h0006);
		i_cpu.wr8(3'h1, 8'h06);
		i_cpu.ext_pulses(5, 3);
		repeat (6) @(negedge clk);
		check("fall ticks", count_value, 16'h000b);
		i_cpu.wr8(3'h1, 8'h00);
		$display("external test done");
	endtask
	task t_modes;
		int tri_seq[9] = '{0, 1, 2, 3, 2, 1, 0, 1, 2};
		i_cpu.wr16(3'h6, 16'h0003);
		i_cpu.wr16(3'h2, 16'h0000);
		// mode 4 on the system clock: clear at ceiling
		i_cpu.wr8(3'h1, 8'h09);
		for (int k = 0; k < 9; k++) begin
			@(negedge clk);
			check("clear at ceiling", count_value, 16'(k % 4));
			check("ceiling flag", count_ceiling, 16'(k % 4 == 3));
		end
		i_cpu.wr8(3'h1, 8'h00);
		// mode 1: up to ceiling, down to floor, overflow at floor
		i_cpu.wr8(3'h0, 8'h01);
		i_cpu.wr16(3'h2, 16'h0000);
		i_cpu.wr8(3'h1, 8'h01);
		for (int k = 0; k < 9; k++) begin
			@(negedge clk);
			check("up down", count_value, 16'(tri_seq[k]));
			check("floor flag", count_floor, 16'(tri_seq[k] == 0));
			check("floor overflow", overflow_flag, 16'(k >= 7));
		end
		i_cpu.wr8(3'h1, 8'h00);
		$display("modes test done");
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			wrap_up();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		t_access();
		t_clk();
		t_presc();
		t_ext();
		t_modes();
		wrap_up();
	end
endmodule
